// [include/gdm_pkg.sv]
// Package with frame layout, command codes, states and register constants of the gate driver mode logic.
package gdm_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 12;
  localparam int CMD_MSB = 11;
  localparam int CMD_LSB = 8;
  localparam int DATA_MSB = 7;
  localparam int DATA_LSB = 0;
  localparam int PTR_BITS = 5;
  localparam int NUM_REGS = 32;
  localparam logic [3:0] ADDR_ALL = 4'h0;
  localparam logic [3:0] ADDR_BCAST = 4'hF;
  localparam logic [3:0] ADDR_RESET = 4'h0;
  // Full frames for fixed commands, address field masked off.
  localparam logic [11:0] CMD_DRIVER_ENABLE_CMD = 12'h009;
  localparam logic [11:0] CMD_DRIVER_DISABLE_CMD = 12'h00A;
  localparam logic [11:0] CMD_CFG_IN = 12'h222;
  localparam logic [11:0] CMD_NOP = 12'h542;
  localparam logic [11:0] CMD_SOFT_RST = 12'h708;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_WR_HI = 4'hA;
  localparam logic [3:0] OP_WR_LO = 4'hB;
  localparam logic [3:0] OP_SET_PTR = 4'hC;
  localparam logic [15:0] FRM_SET_CA_HI = 16'hFDA0;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // Register indices that hold the three bits writable in active.
  localparam logic [4:0] IDX_CONTROL_WORD_TWO = 5'h0A;
  localparam logic [4:0] IDX_CONFIG8 = 5'h07;
  localparam logic [15:0] CONTROL_WORD_TWO_ACTIVE_MASK = 16'h8000;
  localparam logic [15:0] CONFIG8_ACTIVE_MASK = 16'h0003;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  localparam logic [7:0] CRC_POLY = 8'h07;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_CFG1 = 2'b01,
    ST_CFG2 = 2'b11,
    ST_ACTIVE = 2'b10
  } gdm_state_t;
endpackage

// [hdl/gdm_sync.sv]
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
module gdm_sync (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic async_in, // unsynchronised level
  output logic sync_out // synchronised level
);
  typedef struct packed {
    logic meta;
    logic sync;
  } gdm_sync_st_t;
  gdm_sync_st_t s_q, s_d;
  always_comb begin
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
endmodule

// [hdl/gdm_spi_shift.sv]
// SPI slave shifter: CPOL=0, CPHA=1, 16-bit frame latched at chip select rise.
`timescale 1ns/1ps
module gdm_spi_shift (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic sclk_s, // synchronised serial clock
  input wire logic cs_n_s, // synchronised chip select, active low
  input wire logic sdi_s, // synchronised serial input
  input wire logic [15:0] tx_word, // word to send in the next frame
  output logic [15:0] rx_word, // last 16 bits held at frame end
  output logic rx_valid, // one-cycle pulse at frame end
  output logic sdo_bit // serial output data
);
  typedef struct packed {
    logic sclk_d;
    logic cs_d;
    logic [15:0] sh;
    logic [15:0] tx;
    logic [15:0] rx;
    logic rxv;
    logic so;
  } gdm_shift_st_t;
  gdm_shift_st_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.sclk_d = sclk_s;
    s_d.cs_d = cs_n_s;
    s_d.rxv = 1'b0;
    if (cs_n_s) begin
      // Idle frame logic is held in reset. [R17]
      s_d.sh = '0;
      s_d.tx = tx_word;
      s_d.so = tx_word[15];
      if (!s_q.cs_d) begin
        s_d.rx = s_q.sh; // [R16] [R20]
        s_d.rxv = 1'b1;
      end
    end else if (s_q.sclk_d && !sclk_s) begin
      // Falling edge shifts both directions; the chain passes bits through. [R18] [R20]
      s_d.sh = {s_q.sh[14:0], sdi_s};
      s_d.tx = {s_q.tx[14:0], s_q.sh[15]};
      s_d.so = s_q.tx[14];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{sclk_d: 1'b0, cs_d: 1'b1, so: 1'b0, rxv: 1'b0, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  assign rx_word = s_q.rx;
  assign rx_valid = s_q.rxv;
  assign sdo_bit = s_q.so;
endmodule

// [hdl/gdm_mode_ctrl.sv]
// Operating-state machine, frame decoder and register store of the gate driver.
// Operation
// [R1] Current state is readable only in configuration 2 or active.
// [R2] Power-up enters reset: commands ignored, gates off, defaults, self tests run.
// [R3] Fault outputs low until secondary supply, self tests done and configuration 1.
// [R4] After leaving reset, return only on power cycle or primary over-temperature.
// [R5] Secondary over-temperature alone never causes reset.
// [R6] Tests done and link up enter configuration 1, releasing fault outputs.
// [R7] Configuration 1 accepts bus address programming, sink output held low.
// [R8] Enter-configuration command moves configuration 1 to configuration 2.
// [R9] Master sends enter-configuration to each chained device in turn.
// [R10] Chain entry sequence is needed once per power cycle.
// [R11] Configuration 2: registers writable, status live, faults shown, sink low.
// [R12] Driver-enable enters active, sets enable flag, stores configuration checksum.
// [R13] Active: gates follow PWM without fault; only three bits writable.
// [R14] Active left only by soft reset, disable then enter-configuration, or thermal fault.
// [R15] Soft reset clears all but bus address; disable keeps registers.
// [R16] Frames are 16 bits; serial clock at most 4 MHz.
// [R17] Chip select frames the transfer; high holds SPI reset, output released.
// [R18] Clock idles low; data shifts on falling edge.
// [R19] Independent slaves each get their own chip select.
// [R20] Chain: output shifts with input; last 16 bits executed at select rise.
// [R21] Chain master holds select low for the whole chain.
// [R22] Address-based devices share lines and answer only their own address.
// [R23] Frame holds 4-bit address, command field and 8-bit data, MSB first.
// [R24] Serial output released until own address; released again on bad or broadcast.
// [R25] Also accept frames addressed to 0x0 and 0xF.
// [R26] Register pointer persists until a new pointer command or reset.
// [R27] Gates follow PWM only in active, safe level otherwise.
`timescale 1ns/1ps
module gdm_mode_ctrl #(
  parameter int REG_COUNT = gdm_pkg::NUM_REGS // number of 16-bit registers
) (
  input wire logic sys_clk, // 10 MHz system clock
  input wire logic rst, // async reset, active high (power-on)
  input wire logic sclk, // SPI clock pin
  input wire logic chip_select_n, // SPI chip select pin, active low
  input wire logic serial_in, // SPI data in pin
  output logic serial_out, // SPI data out
  output logic serial_out_oe, // SPI data out enable
  input wire logic pwm_in_p, // PWM input, positive
  input wire logic pwm_in_n, // PWM input, negative
  input wire logic sec_supply_ok, // secondary supply present
  input wire logic self_test_done, // all self tests finished
  input wire logic link_up, // primary to secondary link established
  input wire logic pri_over_temp, // primary over-temperature
  input wire logic sec_over_temp, // secondary over-temperature
  input wire logic fault_present, // any fault blocking the gate
  input wire logic alarm_fault, // unmasked alarm fault
  input wire logic warning_fault, // unmasked warning fault
  input wire logic addr_prog_en, // address programming allowed (PWM+ high)
  output logic gate_source_out, // gate source drive
  output logic gate_source_oe, // gate source enable
  output logic gate_sink_out, // gate sink drive
  output logic gate_sink_oe, // gate sink enable
  output logic alarm_out_n, // alarm output, active low
  output logic warning_out_n, // warning output, active low
  output logic self_test_run, // self tests requested
  output logic [1:0] operating_state_field, // state, valid when readable
  output logic state_readable, // state field readable
  output logic enable_received_flag, // driver-enable seen
  output logic [7:0] config_checksum, // checksum stored on entering active
  output logic [3:0] bus_address // programmed bus address
);
  localparam int PW = gdm_pkg::PTR_BITS;

  logic sclk_s, cs_n_s, sdi_s, pwm_p_s, pwm_n_s;
  logic [15:0] rx_word;
  logic rx_valid;
  logic sdo_bit;
  logic [15:0] regs_q [REG_COUNT];

  typedef struct packed {
    gdm_pkg::gdm_state_t st;
    logic [3:0] addr;
    logic [PW-1:0] ptr;
    logic sdo_en;
    logic en_rcvd;
    logic disabled;
    logic [7:0] crc;
    logic [15:0] tx;
    logic wr;
    logic [PW-1:0] wr_idx;
    logic [15:0] wr_data;
    logic wr_clear;
    logic src;
    logic src_oe;
    logic snk;
    logic snk_oe;
  } gdm_mode_st_t;
  gdm_mode_st_t s_q, s_d;

  gdm_sync u_sync_sclk (.sys_clk(sys_clk), .rst(rst), .async_in(sclk), .sync_out(sclk_s));
  gdm_sync u_sync_cs (.sys_clk(sys_clk), .rst(rst), .async_in(chip_select_n), .sync_out(cs_n_s));
  gdm_sync u_sync_sdi (.sys_clk(sys_clk), .rst(rst), .async_in(serial_in), .sync_out(sdi_s));
  gdm_sync u_sync_pp (.sys_clk(sys_clk), .rst(rst), .async_in(pwm_in_p), .sync_out(pwm_p_s));
  gdm_sync u_sync_pn (.sys_clk(sys_clk), .rst(rst), .async_in(pwm_in_n), .sync_out(pwm_n_s));

  gdm_spi_shift u_shift (
    .sys_clk(sys_clk),
    .rst(rst),
    .sclk_s(sclk_s),
    .cs_n_s(cs_n_s),
    .sdi_s(sdi_s),
    .tx_word(s_q.tx),
    .rx_word(rx_word),
    .rx_valid(rx_valid),
    .sdo_bit(sdo_bit)
  );

  // CRC8 over one 16-bit word, polynomial x^8+x^2+x+1.
  function automatic logic [7:0] crc_word(input logic [7:0] c, input logic [15:0] w);
    logic [7:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      if (r[7] ^ w[i]) begin
        r = {r[6:0], 1'b0} ^ gdm_pkg::CRC_POLY;
      end else begin
        r = {r[6:0], 1'b0};
      end
    end
    return r;
  endfunction

  // True when the frame address is ours, the all-devices code or broadcast.
  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] own);
    return (a == own) || (a == gdm_pkg::ADDR_ALL) || (a == gdm_pkg::ADDR_BCAST); // [R22] [R25]
  endfunction

  // Bits that software may still change while active.
  function automatic logic [15:0] active_mask(input logic [PW-1:0] idx);
    if (idx == gdm_pkg::IDX_CONTROL_WORD_TWO) begin
      return gdm_pkg::CONTROL_WORD_TWO_ACTIVE_MASK;
    end else if (idx == gdm_pkg::IDX_CONFIG8) begin
      return gdm_pkg::CONFIG8_ACTIVE_MASK;
    end
    return 16'h0000;
  endfunction

  always_comb begin
    logic [3:0] fa;
    logic [3:0] op;
    logic [11:0] body;
    logic hit;
    logic [7:0] c;
    logic [15:0] m;
    logic [15:0] cur;
    fa = rx_word[gdm_pkg::ADDR_MSB:gdm_pkg::ADDR_LSB]; // [R23]
    op = rx_word[gdm_pkg::CMD_MSB:gdm_pkg::CMD_LSB];
    body = rx_word[gdm_pkg::CMD_MSB:0];
    hit = addr_hit(fa, s_q.addr);
    c = gdm_pkg::CRC_INIT;
    m = 16'h0000;
    cur = regs_q[s_q.ptr];
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.wr_clear = 1'b0;
    // Reset state is left only when tests and the link are both done. [R6]
    if (s_q.st == gdm_pkg::ST_RESET) begin
      // Held in reset while the primary side is still hot, so the state cannot toggle.
      if (self_test_done && link_up && sec_supply_ok && !pri_over_temp) begin // [R4]
        s_d.st = gdm_pkg::ST_CFG1;
      end
    end else if (pri_over_temp) begin
      // Only the primary sensor forces reset; secondary alone does not. [R4] [R5]
      s_d.st = gdm_pkg::ST_RESET;
      s_d.sdo_en = 1'b0;
      s_d.en_rcvd = 1'b0;
      s_d.disabled = 1'b0;
      s_d.wr_clear = 1'b1;
      s_d.ptr = '0;
    end else if (rx_valid) begin
      if (rx_word[15:4] == gdm_pkg::FRM_SET_CA_HI[15:4]) begin
        // Address programming only in configuration 1. [R7]
        if (s_q.st == gdm_pkg::ST_CFG1 && addr_prog_en) begin
          s_d.addr = rx_word[3:0];
        end
      end else if (!hit) begin
        s_d.sdo_en = 1'b0; // [R24]
      end else begin
        s_d.sdo_en = (fa == s_q.addr) && (fa != gdm_pkg::ADDR_BCAST); // [R24]
        if (body == gdm_pkg::CMD_CFG_IN) begin
          if (s_q.st == gdm_pkg::ST_CFG1) begin
            s_d.st = gdm_pkg::ST_CFG2; // [R8]
          end else if (s_q.st == gdm_pkg::ST_ACTIVE && s_q.disabled) begin
            s_d.st = gdm_pkg::ST_CFG2; // [R14]
            s_d.disabled = 1'b0;
          end
        end else if (body == gdm_pkg::CMD_DRIVER_ENABLE_CMD && s_q.st == gdm_pkg::ST_CFG2) begin
          // Checksum taken over the whole register store on entry. [R12]
          for (int i = 0; i < REG_COUNT; i++) begin
            c = crc_word(c, regs_q[i]);
          end
          s_d.crc = c;
          s_d.en_rcvd = 1'b1;
          s_d.st = gdm_pkg::ST_ACTIVE;
        end else if (body == gdm_pkg::CMD_DRIVER_DISABLE_CMD && s_q.st == gdm_pkg::ST_ACTIVE) begin
          s_d.disabled = 1'b1; // [R15]
        end else if (body == gdm_pkg::CMD_SOFT_RST && s_q.st != gdm_pkg::ST_CFG1) begin
          // Registers cleared, bus address kept. [R14] [R15]
          s_d.wr_clear = 1'b1;
          s_d.st = gdm_pkg::ST_CFG2;
          s_d.en_rcvd = 1'b0;
          s_d.disabled = 1'b0;
          s_d.ptr = '0;
        end else if (op == gdm_pkg::OP_SET_PTR) begin
          s_d.ptr = rx_word[PW-1:0]; // [R26]
        end else if (op == gdm_pkg::OP_READ) begin
          s_d.tx = regs_q[rx_word[PW-1:0]];
        end else if ((op == gdm_pkg::OP_WR_HI || op == gdm_pkg::OP_WR_LO) &&
                     (s_q.st == gdm_pkg::ST_CFG2 || s_q.st == gdm_pkg::ST_ACTIVE)) begin
          m = (op == gdm_pkg::OP_WR_HI) ? 16'hFF00 : 16'h00FF;
          if (s_q.st == gdm_pkg::ST_ACTIVE) begin
            m = m & active_mask(s_q.ptr); // [R13]
          end
          s_d.wr = 1'b1; // [R11]
          s_d.wr_idx = s_q.ptr;
          s_d.wr_data = (cur & ~m) | ({rx_word[7:0], rx_word[7:0]} & m);
        end
      end
    end
    // Gates: high-Z in reset, sink low until active, PWM only when active and clean.
    s_d.src = 1'b0;
    s_d.snk = 1'b0;
    s_d.src_oe = 1'b0;
    s_d.snk_oe = 1'b0;
    if (s_q.st == gdm_pkg::ST_ACTIVE && !s_q.disabled && !fault_present) begin
      s_d.src_oe = pwm_p_s && !pwm_n_s; // [R13] [R27]
      s_d.src = pwm_p_s && !pwm_n_s;
      s_d.snk_oe = !(pwm_p_s && !pwm_n_s);
    end else if (s_q.st != gdm_pkg::ST_RESET) begin
      s_d.snk_oe = 1'b1; // [R7] [R11] [R27]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{st: gdm_pkg::ST_RESET, addr: gdm_pkg::ADDR_RESET, crc: gdm_pkg::CRC_INIT,
               default: '0}; // [R2]
    end else begin
      s_q <= s_d;
    end
  end

  // Register store; defaults loaded on power-up and soft reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= gdm_pkg::REG_RESET;
      end
    end else if (s_q.wr_clear) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= gdm_pkg::REG_RESET; // [R15]
      end
    end else if (s_q.wr) begin
      regs_q[s_q.wr_idx] <= s_q.wr_data;
    end
  end

  logic st_ok;
  assign st_ok = (s_q.st == gdm_pkg::ST_CFG2) || (s_q.st == gdm_pkg::ST_ACTIVE);
  assign state_readable = st_ok; // [R1]
  assign operating_state_field = st_ok ? s_q.st : 2'b00; // [R1]
  assign serial_out = sdo_bit;
  assign serial_out_oe = s_q.sdo_en && !cs_n_s; // [R17] [R24]
  assign gate_source_out = s_q.src;
  assign gate_source_oe = s_q.src_oe;
  assign gate_sink_out = s_q.snk;
  assign gate_sink_oe = s_q.snk_oe;
  // Fault pins low until configuration 1 is reached, then unmasked faults only. [R3] [R11]
  assign alarm_out_n = (s_q.st != gdm_pkg::ST_RESET) && !alarm_fault;
  assign warning_out_n = (s_q.st != gdm_pkg::ST_RESET) && !warning_fault;
  assign self_test_run = (s_q.st == gdm_pkg::ST_RESET); // [R2]
  assign enable_received_flag = s_q.en_rcvd;
  assign config_checksum = s_q.crc;
  assign bus_address = s_q.addr;

  a_reset_faults_low: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.st == gdm_pkg::ST_RESET) |-> (!alarm_out_n && !warning_out_n)) // [R3]
    else $error("fault outputs released in reset");
  a_sec_temp_no_reset: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.st != gdm_pkg::ST_RESET && !pri_over_temp) |=> (s_q.st != gdm_pkg::ST_RESET)) // [R5]
    else $error("reset entered without primary over-temperature");
  a_pri_temp_reset: assert property (@(posedge sys_clk) disable iff (rst)
    pri_over_temp |=> (s_q.st == gdm_pkg::ST_RESET)) // [R4]
    else $error("primary over-temperature did not reset");
  a_enable_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    ($past(s_q.st) == gdm_pkg::ST_CFG2 && s_q.st == gdm_pkg::ST_ACTIVE) |-> s_q.en_rcvd) // [R12]
    else $error("enable flag not set on active entry");
  a_gate_safe_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.st != gdm_pkg::ST_ACTIVE) |=> !gate_source_oe) // [R27]
    else $error("source driven outside active");
  a_reset_gates_hiz: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.st == gdm_pkg::ST_RESET) |=> (!gate_sink_oe || s_q.st != gdm_pkg::ST_RESET)) // [R2]
    else $error("gate driven in reset");
  a_state_hidden: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.st == gdm_pkg::ST_CFG1) |-> (!state_readable && operating_state_field == 2'b00)) // [R1]
    else $error("state visible in configuration 1");
  a_sdo_idle_off: assert property (@(posedge sys_clk) disable iff (rst)
    cs_n_s |-> !serial_out_oe) // [R17]
    else $error("serial out driven with select high");
endmodule

// [sim/gdm_spi_master.sv]
// Behavioural SPI master that frames 16-bit commands toward the gate driver.
`timescale 1ns/1ps
module gdm_spi_master (
  sclk, // serial clock, still and low between frames
  cs_n, // chip select to this one device, active low
  mosi, // serial data toward the device
  miso, // resolved serial data from the device
  rx_word // word captured during the last frame
);
  output logic sclk;
  output logic cs_n;
  output logic mosi;
  input wire logic miso;
  output logic [15:0] rx_word;
  // A 400 ns half period gives 1.25 MHz, inside the device limit.
  localparam int HALF_NS = 400;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx_word = 16'h0000;
  end
  task automatic xfer(input logic [15:0] w);
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b1;
      mosi = w[i];
      #(HALF_NS);
      sclk = 1'b0;
      rx_word[i] = miso;
      #(HALF_NS);
    end
    cs_n = 1'b1;
    // The line is not held after the frame, so a stale bit cannot pass for data.
    mosi = ~mosi;
    #(HALF_NS);
  endtask
endmodule

// [sim/gdm_spi_slave_tb_top.sv]
// Self-checking testbench for the gate driver mode logic and its SPI slave.
`timescale 1ns/1ps
module gate_driver_mode_fsm_spi_slave_tb_top;
  typedef struct {logic [1:0] kind; string nm; logic [15:0] exp; logic [15:0] mk;} gdm_note_t;
  logic sys_clk, rst, sclk, cs_n, mosi, miso, serial_out, serial_out_oe;
  logic pwm_in_p, pwm_in_n, sec_supply_ok, self_test_done, link_up, pri_over_temp;
  logic sec_over_temp, fault_present, alarm_fault, warning_fault, addr_prog_en;
  logic gate_source_out, gate_source_oe, gate_sink_out, gate_sink_oe, alarm_out_n;
  logic warning_out_n, self_test_run, state_readable, enable_received_flag;
  logic [1:0] operating_state_field;
  logic [7:0] config_checksum;
  logic [3:0] bus_address, ca_exp;
  logic [15:0] rx_w, snap, seen;
  logic miso_flt = 1'b0;
  logic en_exp, drv_on;
  int fails = 0;
  int tests_run = 0;
  int seed;
  int r;
  gdm_note_t notes[$];
  gdm_note_t n;
  event chk_ev;
  gdm_mode_ctrl uut (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .chip_select_n(cs_n),
    .serial_in(mosi), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .pwm_in_p(pwm_in_p), .pwm_in_n(pwm_in_n), .sec_supply_ok(sec_supply_ok),
    .self_test_done(self_test_done), .link_up(link_up), .pri_over_temp(pri_over_temp),
    .sec_over_temp(sec_over_temp), .fault_present(fault_present), .alarm_fault(alarm_fault),
    .warning_fault(warning_fault), .addr_prog_en(addr_prog_en),
    .gate_source_out(gate_source_out), .gate_source_oe(gate_source_oe),
    .gate_sink_out(gate_sink_out), .gate_sink_oe(gate_sink_oe), .alarm_out_n(alarm_out_n),
    .warning_out_n(warning_out_n), .self_test_run(self_test_run),
    .operating_state_field(operating_state_field), .state_readable(state_readable),
    .enable_received_flag(enable_received_flag), .config_checksum(config_checksum),
    .bus_address(bus_address));
  gdm_spi_master m (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .rx_word(rx_w));
  // A released data line shows a pattern that changes every cycle, never the last bit.
  always @(posedge sys_clk) miso_flt <= ~miso_flt;
  assign miso = serial_out_oe ? serial_out : miso_flt;
  assign snap = {self_test_run, serial_out_oe, gate_sink_out, gate_sink_oe, gate_source_out,
    gate_source_oe, warning_out_n, alarm_out_n, bus_address, enable_received_flag,
    state_readable, operating_state_field};
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] expv(gdm_pkg::gdm_state_t st);
    logic [15:0] v;
    logic rd;
    logic on;
    rd = (st == gdm_pkg::ST_CFG2) || (st == gdm_pkg::ST_ACTIVE);
    on = (st == gdm_pkg::ST_ACTIVE) && drv_on && pwm_in_p && !pwm_in_n && !fault_present;
    v = 16'h0000;
    v[1:0] = rd ? st : 2'h0;
    v[2] = rd;
    v[3] = en_exp;
    v[7:4] = ca_exp;
    if (st == gdm_pkg::ST_RESET) begin
      v[15] = 1'b1;
    end else begin
      v[8] = !alarm_fault;
      v[9] = !warning_fault;
      v[10] = on;
      v[11] = on;
      v[12] = !on;
    end
    return v;
  endfunction
  // Checksum over the 32-word store; words other than 3 and 7 hold zero in these scenarios.
  function automatic logic [7:0] crc_exp(input logic [15:0] r3, input logic [15:0] r7);
    logic [7:0] c;
    logic [15:0] w;
    c = 8'hFF;
    for (int i = 0; i < 32; i++) begin
      w = (i == 3) ? r3 : ((i == 7) ? r7 : 16'h0000);
      for (int b = 15; b >= 0; b--) begin
        c = (c[7] ^ w[b]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
  task automatic note(input logic [1:0] k, input string nm, input logic [15:0] e,
                      input logic [15:0] mk);
    notes.push_back('{k, nm, e, mk});
    -> chk_ev;
    @(negedge sys_clk);
  endtask
  task automatic chk(input string nm, input gdm_pkg::gdm_state_t st,
                     input logic [15:0] mk = 16'hFFFF);
    // Address, flag and drive levels are not defined while the device sits in reset.
    note(2'h0, nm, expv(st), (st == gdm_pkg::ST_RESET) ? (mk & 16'hD707) : mk);
  endtask
  task automatic fr(input logic [15:0] w);
    m.xfer(w);
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] hi, input logic [7:0] lo);
    fr({ca_exp, gdm_pkg::OP_SET_PTR, 3'h0, idx});
    fr({ca_exp, gdm_pkg::OP_WR_HI, hi});
    fr({ca_exp, gdm_pkg::OP_WR_LO, lo});
  endtask
  task automatic rd(input logic [4:0] idx, input logic [15:0] ev);
    fr({ca_exp, gdm_pkg::OP_READ, 3'h0, idx});
    fr({ca_exp, gdm_pkg::CMD_NOP});
    note(2'h1, "read data", ev, 16'hFFFF);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(chk_ev) begin
    n = notes.pop_front();
    seen = (n.kind == 2'h2) ? {8'h00, config_checksum} : ((n.kind == 2'h1) ? rx_w : snap);
    tests_run++;
    if (((seen ^ n.exp) & n.mk) !== 16'h0000) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n.nm, n.exp, seen);
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    fails++;
    $display("wrong value watchdog expected finish seen hang");
    end_sim();
  end
  initial begin
    seed = 32'h201d4a1b;
    {rst, pwm_in_p, pwm_in_n, sec_supply_ok, self_test_done, link_up} = 6'b100000;
    {pri_over_temp, sec_over_temp, fault_present, alarm_fault, warning_fault} = 5'b00000;
    {addr_prog_en, en_exp, drv_on, ca_exp} = 7'h00;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    chk("reset outputs", gdm_pkg::ST_RESET);
    self_test_done = 1'b1;
    link_up = 1'b1;
    fr({gdm_pkg::ADDR_ALL, gdm_pkg::CMD_CFG_IN});
    chk("no second supply", gdm_pkg::ST_RESET);
    sec_supply_ok = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk("config one", gdm_pkg::ST_CFG1);
    sec_over_temp = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk("secondary heat", gdm_pkg::ST_CFG1);
    sec_over_temp = 1'b0;
    {pwm_in_p, addr_prog_en} = 2'b11;
    fr(gdm_pkg::FRM_SET_CA_HI | 16'h0005);
    ca_exp = 4'h5;
    addr_prog_en = 1'b0;
    chk("address set", gdm_pkg::ST_CFG1);
    fr({gdm_pkg::ADDR_BCAST, gdm_pkg::CMD_CFG_IN});
    chk("config two", gdm_pkg::ST_CFG2);
    wr(5'h03, 8'hA5, 8'h3C);
    rd(5'h03, 16'hA53C);
    wr(gdm_pkg::IDX_CONFIG8, 8'h00, 8'h00);
    fr({4'h3, gdm_pkg::CMD_DRIVER_ENABLE_CMD});
    chk("foreign address", gdm_pkg::ST_CFG2);
    fr({ca_exp, gdm_pkg::CMD_DRIVER_ENABLE_CMD});
    {en_exp, drv_on} = 2'b11;
    chk("active", gdm_pkg::ST_ACTIVE);
    note(2'h2, "checksum", {8'h00, crc_exp(16'hA53C, 16'h0000)}, 16'h00FF);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      {pwm_in_p, pwm_in_n, fault_present, alarm_fault, warning_fault} = r[4:0];
      repeat (10) @(negedge sys_clk);
      chk("gate follow", gdm_pkg::ST_ACTIVE);
    end
    {pwm_in_p, pwm_in_n, fault_present, alarm_fault, warning_fault} = 5'b10000;
    wr(5'h03, 8'h00, 8'h00);
    rd(5'h03, 16'hA53C);
    wr(gdm_pkg::IDX_CONFIG8, 8'hFF, 8'hFF);
    rd(gdm_pkg::IDX_CONFIG8, gdm_pkg::CONFIG8_ACTIVE_MASK);
    fr({ca_exp, gdm_pkg::CMD_CFG_IN});
    chk("stay active", gdm_pkg::ST_ACTIVE);
    fr({ca_exp, gdm_pkg::CMD_DRIVER_DISABLE_CMD});
    drv_on = 1'b0;
    chk("driver off", gdm_pkg::ST_ACTIVE);
    fr({ca_exp, gdm_pkg::CMD_CFG_IN});
    chk("back to config", gdm_pkg::ST_CFG2);
    rd(5'h03, 16'hA53C);
    fr({ca_exp, gdm_pkg::CMD_DRIVER_ENABLE_CMD});
    drv_on = 1'b1;
    chk("active again", gdm_pkg::ST_ACTIVE);
    fr({ca_exp, gdm_pkg::CMD_SOFT_RST});
    {en_exp, drv_on} = 2'b00;
    chk("soft reset", gdm_pkg::ST_CFG2);
    rd(5'h03, gdm_pkg::REG_RESET);
    fr({ca_exp, gdm_pkg::CMD_DRIVER_ENABLE_CMD});
    {en_exp, drv_on} = 2'b11;
    chk("active third", gdm_pkg::ST_ACTIVE);
    note(2'h2, "checksum again", {8'h00, crc_exp(16'h0000, 16'h0000)}, 16'h00FF);
    pri_over_temp = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk("primary heat", gdm_pkg::ST_RESET);
    pri_over_temp = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("reentry", gdm_pkg::ST_CFG1, 16'hFF07);
    end_sim();
  end
endmodule
